// File: shared/sfs_pkg.sv
// Purpose: Shared constants and types for the flash status register block.
// Assumes: System clock of 50 MHz; link follows serial mode 0 or 3, MSB first.
// Notes: The long write time is a default only; the top exposes it as a parameter.
package sfs_pkg;

	// Status register layout.
	localparam int SR_W = 8;
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 5;
	localparam int SR_QE = 6;
	localparam int SR_STATUS_WRITE_DISABLE = 7;
	localparam logic [7:0] SR_RESET = 8'h00;

	// Instruction codes.
	localparam logic [7:0] CMD_SET_WE = 8'h06;
	localparam logic [7:0] CMD_CLEAR_WE = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_SECTOR_ERASE_ALT = 8'hD7;
	localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_SUSPEND_ALT = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_RESUME_ALT = 8'h30;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h99;

	// Frame lengths in link clock edges.
	localparam logic [5:0] BITS_OP = 6'h08;
	localparam logic [5:0] BITS_DATA = 6'h10;
	localparam logic [5:0] BITS_ADDR = 6'h20;

	// Array address map.
	localparam int ADDR_W = 24;
	localparam int SECTOR_SH = 12;
	localparam int BLK32_SH = 15;
	localparam int BLK64_SH = 16;

	// Timing.
	localparam int CLK_MHZ = 50;
	localparam int NV_WRITE_US = 2000;
	localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_PROGRAM,
		OP_SECTOR_ERASE,
		OP_BLOCK32_ERASE,
		OP_BLOCK64_ERASE,
		OP_CHIP_ERASE
	} sfs_op_e;

	typedef enum logic [1:0] {
		ST_READY,
		ST_ARRAY,
		ST_NV_WRITE
	} sfs_state_e;

	typedef struct packed {
		logic [7:0] opcode;
		logic [ADDR_W-1:0] arg;
		logic [5:0] bits;
	} sfs_frame_s;

	typedef struct packed {
		logic start;
		logic resume;
		sfs_op_e kind;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-SECTOR_SH-1:0] sector;
		logic [ADDR_W-BLK32_SH-1:0] block32;
		logic [ADDR_W-BLK64_SH-1:0] block64;
	} sfs_op_s;

endpackage

// File: design/sfs_link.sv
// Purpose: Link-side shifter on the serial clock; captures a frame, sends status.
// Assumes: Input sampled on rising edge, output changed on falling edge.
// Notes: Chip enable high ends the frame; the serial clock may stop between frames.
`timescale 1ns/100ps
module sfs_link (
	input wire logic link_sck,
	input wire logic ce_b,
	input wire logic si,
	input wire logic [7:0] shown_status,
	output sfs_pkg::sfs_frame_s frame,
	output logic so,
	output logic so_oe
);
	import sfs_pkg::*;

	typedef struct packed {
		sfs_frame_s fr;
		logic [7:0] in_sh;
		logic [7:0] out_sh;
		logic reading;
	} sfs_link_s;

	sfs_link_s st_r;
	sfs_link_s st_nxt;
	logic fresh_r;
	logic so_r;
	logic so_oe_r;
	logic [5:0] base;
	logic [7:0] opcode_in;

	// The frame counter cannot be cleared on the serial clock, since it stops
	// once chip enable rises; this flag marks that the next edge opens a frame.
	always_ff @(posedge link_sck or posedge ce_b) begin
		if (ce_b) begin
			fresh_r <= 1'b1;
		end else begin
			fresh_r <= 1'b0;
		end
	end

	always_comb begin
		st_nxt = st_r;
		base = fresh_r ? 6'h00 : st_r.fr.bits;
		opcode_in = {st_r.in_sh[6:0], si};
		if (fresh_r) begin
			st_nxt.reading = 1'b0;
		end
		if (base != BITS_ADDR) begin
			st_nxt.fr.bits = base + 6'h01;
		end
		st_nxt.in_sh = opcode_in;
		if (base == BITS_OP - 6'h01) begin
			st_nxt.fr.opcode = opcode_in;
			if (opcode_in == CMD_STATUS_READ) begin
				st_nxt.reading = 1'b1;
				st_nxt.out_sh = shown_status;
			end
		end else if (base >= BITS_OP && base < BITS_ADDR) begin
			st_nxt.fr.arg = {st_r.fr.arg[ADDR_W-2:0], si};
		end
		if (st_r.reading && !fresh_r) begin
			st_nxt.out_sh = {st_r.out_sh[6:0], st_r.out_sh[7]};
		end
	end

	always_ff @(posedge link_sck) begin
		st_r <= st_nxt;
	end

	always_ff @(negedge link_sck or posedge ce_b) begin
		if (ce_b) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_r <= st_r.out_sh[7];
			so_oe_r <= st_r.reading & ~fresh_r;
		end
	end

	assign frame = st_r.fr;
	assign so = so_r;
	assign so_oe = so_oe_r;

endmodule // sfs_link

// File: design/sfs_status_top.sv
// Purpose: Status register of a serial flash with write gating and busy control.
// Assumes: Frames are decoded at chip enable release; array engine runs on clk.
// Notes: Nonvolatile cells are modelled as flops loaded after the write time.
`timescale 1ns/100ps
module sfs_status_top #(
	parameter int NV_WRITE_CYCLES = sfs_pkg::NV_WRITE_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_sck,
	input wire logic ce_b,
	input wire logic si,
	input wire logic wp_b,
	input wire logic array_done,
	output logic so,
	output logic so_oe,
	output logic [sfs_pkg::SR_W-1:0] flash_status,
	output logic quad_lines_enable,
	output sfs_pkg::sfs_op_s array_op,
	output logic suspend_req,
	output logic soft_reset
);
	import sfs_pkg::*;

	localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

	generate
		if (NV_WRITE_CYCLES < 1) begin : g_bad_write_time
			$error("NV_WRITE_CYCLES must be at least one");
		end
	endgenerate

	typedef struct packed {
		logic ce_s1;
		logic ce_s2;
		logic ce_s3;
		logic wp_s1;
		logic wp_s2;
		logic [SR_W-1:0] sr;
		logic [SR_W-1:0] shown;
		logic [SR_BP_HI-SR_BP_LO+2:0] nv_pending;
		sfs_state_e state;
		logic suspended;
		logic [CNT_W-1:0] nv_cnt;
		sfs_op_s op;
		logic suspend_req;
		logic soft_reset;
	} sfs_top_s;

	sfs_top_s st_r;
	sfs_top_s st_nxt;
	sfs_frame_s frame;
	logic frame_end;
	logic hw_lock;
	logic is_op;
	logic is_data;
	logic is_addr;
	logic launch;
	sfs_op_e kind;
	logic [ADDR_W-1:0] unit_addr;

	// Chip enable acts here only as the frame boundary; the captured frame is
	// still once the serial clock stops, so reading it after the synchronised
	// release is safe as long as the host keeps chip enable high long enough.
	sfs_link u_link (
		.link_sck(link_sck),
		.ce_b(ce_b),
		.si(si),
		.shown_status(st_r.shown),
		.frame(frame),
		.so(so),
		.so_oe(so_oe)
	);

	always_comb begin
		st_nxt = st_r;
		launch = 1'b0;
		kind = OP_NONE;
		unit_addr = frame.arg;

		st_nxt.ce_s1 = ce_b;
		st_nxt.ce_s2 = st_r.ce_s1;
		st_nxt.ce_s3 = st_r.ce_s2;
		st_nxt.wp_s1 = wp_b;
		st_nxt.wp_s2 = st_r.wp_s1;
		st_nxt.op.start = 1'b0;
		st_nxt.op.resume = 1'b0;
		st_nxt.suspend_req = 1'b0;
		st_nxt.soft_reset = 1'b0;

		frame_end = st_r.ce_s2 & ~st_r.ce_s3;
		is_op = frame.bits == BITS_OP;
		is_data = frame.bits == BITS_DATA;
		is_addr = frame.bits == BITS_ADDR;

		// With four-line mode on, the protect pin serves as data and cannot lock.
		hw_lock = st_r.sr[SR_STATUS_WRITE_DISABLE] & ~st_r.wp_s2 & ~st_r.sr[SR_QE];

		case (st_r.state)
			ST_READY: begin
			end
			ST_ARRAY: begin
				if (array_done) begin
					st_nxt.state = ST_READY;
					st_nxt.sr[SR_BUSY] = 1'b0;
					if (!st_r.suspended) begin
						st_nxt.sr[SR_WEL] = 1'b0;
					end
				end
			end
			ST_NV_WRITE: begin
				if (st_r.nv_cnt == '0) begin
					st_nxt.state = ST_READY;
					st_nxt.sr[SR_BUSY] = 1'b0;
					st_nxt.sr[SR_WEL] = 1'b0;
					st_nxt.sr[SR_STATUS_WRITE_DISABLE:SR_BP_LO] = st_r.nv_pending;
				end else begin
					st_nxt.nv_cnt = st_r.nv_cnt - CNT_W'(1);
				end
			end
			default: begin
				st_nxt.state = ST_READY;
			end
		endcase

		if (frame_end) begin
			if (st_r.sr[SR_BUSY]) begin
				// Register reads are served on the link; soft reset acts, suspend acts only on an array operation not yet suspended, anything else is dropped.
				if (is_op && frame.opcode == CMD_SOFT_RESET) begin
					st_nxt.soft_reset = 1'b1;
				end else if (is_op && st_r.state == ST_ARRAY && !st_r.suspended &&
					(frame.opcode == CMD_SUSPEND || frame.opcode == CMD_SUSPEND_ALT)) begin
					st_nxt.suspend_req = 1'b1;
					st_nxt.suspended = 1'b1;
				end
			end else begin
				case (frame.opcode)
					CMD_SET_WE: begin
						if (is_op) begin
							st_nxt.sr[SR_WEL] = 1'b1;
						end
					end
					CMD_CLEAR_WE: begin
						if (is_op) begin
							st_nxt.sr[SR_WEL] = 1'b0;
						end
					end
					CMD_SOFT_RESET: begin
						if (is_op) begin
							st_nxt.soft_reset = 1'b1;
						end
					end
					CMD_STATUS_WRITE: begin
						if (is_data && st_r.sr[SR_WEL] && !hw_lock) begin
							// Data bits 1 and 0 are dropped; the latch is cleared when the write ends.
							st_nxt.nv_pending = frame.arg[SR_STATUS_WRITE_DISABLE:SR_BP_LO];
							st_nxt.state = ST_NV_WRITE;
							st_nxt.sr[SR_BUSY] = 1'b1;
							st_nxt.nv_cnt = CNT_W'(NV_WRITE_CYCLES - 1);
						end
					end
					CMD_PROGRAM: begin
						launch = is_addr;
						kind = OP_PROGRAM;
					end
					CMD_SECTOR_ERASE, CMD_SECTOR_ERASE_ALT: begin
						launch = is_addr;
						kind = OP_SECTOR_ERASE;
						unit_addr = {frame.arg[ADDR_W-1:SECTOR_SH], SECTOR_SH'(0)};
					end
					CMD_BLOCK32_ERASE: begin
						launch = is_addr;
						kind = OP_BLOCK32_ERASE;
						unit_addr = {frame.arg[ADDR_W-1:BLK32_SH], BLK32_SH'(0)};
					end
					CMD_BLOCK64_ERASE: begin
						launch = is_addr;
						kind = OP_BLOCK64_ERASE;
						unit_addr = {frame.arg[ADDR_W-1:BLK64_SH], BLK64_SH'(0)};
					end
					CMD_CHIP_ERASE, CMD_CHIP_ERASE_ALT: begin
						// A chip erase would breach any protected area, so it is dropped
						// unless every protect bit is clear.
						launch = is_op && st_r.sr[SR_BP_HI:SR_BP_LO] == '0;
						kind = OP_CHIP_ERASE;
						unit_addr = '0;
					end
					CMD_RESUME, CMD_RESUME_ALT: begin
						if (is_op && st_r.suspended) begin
							st_nxt.suspended = 1'b0;
							st_nxt.op.resume = 1'b1;
							st_nxt.state = ST_ARRAY;
							st_nxt.sr[SR_BUSY] = 1'b1;
						end
					end
					default: begin
					end
				endcase

				// While an operation is suspended a new array write is refused.
				if (launch && st_r.sr[SR_WEL] && !st_r.suspended) begin
					st_nxt.op.start = 1'b1;
					st_nxt.op.kind = kind;
					st_nxt.op.addr = unit_addr;
					st_nxt.op.sector = unit_addr[ADDR_W-1:SECTOR_SH];
					st_nxt.op.block32 = unit_addr[ADDR_W-1:BLK32_SH];
					st_nxt.op.block64 = unit_addr[ADDR_W-1:BLK64_SH];
					st_nxt.state = ST_ARRAY;
					st_nxt.sr[SR_BUSY] = 1'b1;
				end
			end
		end

		// A reset instruction abandons any write; unfinished data may be lost.
		if (st_nxt.soft_reset) begin
			st_nxt.state = ST_READY;
			st_nxt.sr[SR_BUSY] = 1'b0;
			st_nxt.sr[SR_WEL] = 1'b0;
			st_nxt.suspended = 1'b0;
		end

		// The copy for the link only moves between frames so it is still while read.
		if (st_r.ce_s2) begin
			st_nxt.shown = st_nxt.sr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.sr <= SR_RESET;
			st_r.shown <= SR_RESET;
			st_r.ce_s1 <= 1'b1;
			st_r.ce_s2 <= 1'b1;
			st_r.ce_s3 <= 1'b1;
			st_r.wp_s1 <= 1'b1;
			st_r.wp_s2 <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flash_status = st_r.sr;
	assign quad_lines_enable = st_r.sr[SR_QE];
	assign array_op = st_r.op;
	assign suspend_req = st_r.suspend_req;
	assign soft_reset = st_r.soft_reset;

endmodule // sfs_status_top

// File: verif/sfs_status_chk.sv
// Purpose: Concurrent checks on the ports of the status register block.
// Assumes: Link lines are sampled on clk; host edges never meet clk edges.
// Notes: Link timing in detail is judged by the bench.
`timescale 1ns/100ps
module sfs_status_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_sck,
	input wire logic ce_b,
	input wire logic si,
	input wire logic wp_b,
	input wire logic array_done,
	input wire logic so,
	input wire logic so_oe,
	input wire logic [sfs_pkg::SR_W-1:0] flash_status,
	input wire logic quad_lines_enable,
	input wire sfs_pkg::sfs_op_s array_op,
	input wire logic suspend_req,
	input wire logic soft_reset
);
	import sfs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_ready;
		##1 !flash_status[SR_BUSY];
	endsequence
	sequence s_aligned;
		array_op.addr[11:0] == 12'h000 ##0 array_op.sector == array_op.addr[23:12];
	endsequence
	chk_reset_zero: assert property (disable iff (1'b0) !rst_b |=> flash_status == 8'h00)
		else $error("status not zero after reset");
	chk_qe_mirror: assert property (quad_lines_enable == flash_status[SR_QE])
		else $error("quad enable port differs from bit 6");
	chk_start_busy: assert property (array_op.start |-> flash_status[SR_BUSY] ##1 !array_op.start)
		else $error("array start without busy or longer than one cycle");
	chk_done_ready: assert property (flash_status[SR_BUSY] && array_done |-> s_ready)
		else $error("busy not cleared after array done");
	chk_wel_rise: assert property ($rose(flash_status[SR_WEL]) |-> ce_b && !$past(flash_status[SR_BUSY]))
		else $error("latch set while busy or inside a frame");
	chk_nv_hidden: assert property (!$stable(flash_status[7:2]) |-> $fell(flash_status[SR_BUSY]))
		else $error("stored bits changed before busy cleared");
	chk_link_idle: assert property (ce_b |-> !so_oe && !so)
		else $error("output driven with chip enable high");
	chk_erase_align: assert property (array_op.start && array_op.kind == OP_SECTOR_ERASE |-> s_aligned)
		else $error("sector erase address not aligned");
	chk_soft_clear: assert property (soft_reset |-> ##[0:1] flash_status[1:0] == 2'b00)
		else $error("soft reset left busy or latch set");
	chk_susp_pulse: assert property (suspend_req |=> !suspend_req)
		else $error("suspend request longer than one cycle");
endmodule // sfs_status_chk

// File: verif/sfs_host.sv
// Purpose: Host model that frames instructions on the serial link.
// Assumes: Mode 0, 64 ns per bit, MSB first.
// Notes: The clock stands low between frames; the data line flips when released.
`timescale 1ns/100ps
module sfs_host (
	output logic link_sck,
	output logic ce_b,
	output logic si,
	input wire logic so
);
	initial begin
		link_sck = 1'b0;
		ce_b = 1'b1;
		si = 1'b0;
	end
	task automatic xfer(input logic [31:0] d, input int n, output logic [15:0] rd);
		rd = 16'h0000;
		ce_b = 1'b0;
		#50;
		for (int i = 0; i < n; i++) begin
			si = d[31-i];
			#32 link_sck = 1'b1;
			rd = {rd[14:0], so};
			#32 link_sck = 1'b0;
		end
		#32 ce_b = 1'b1;
		si = ~si;
		#100;
	endtask
endmodule // sfs_host

// File: verif/test_sfs_status_top.sv
// Purpose: Self-checking bench for the flash status register block.
// Assumes: Write time shortened to 300 cycles.
// Notes: Rows run in order; each depends on the state left by the one before.
`timescale 1ns/100ps
module test_sfs_status_top;
	import sfs_pkg::*;
	typedef struct packed {
		logic [31:0] d;
		logic [7:0] n;
		logic [15:0] w;
		logic [7:0] e;
	} sfs_row_s;
	logic clk;
	logic rst_b;
	logic wp_b;
	logic array_done;
	wire link_sck;
	wire ce_b;
	wire si;
	wire so_line;
	logic so;
	logic so_oe;
	logic [SR_W-1:0] flash_status;
	logic quad_lines_enable;
	sfs_op_s array_op;
	logic suspend_req;
	logic soft_reset;
	int n_mismatch;
	int n_tests;
	logic [15:0] rd;
	sfs_row_s rows [9];
	// A released line shows the inverse so a stale bit cannot pass.
	assign so_line = so_oe ? so : ~so;
	sfs_status_top #(.NV_WRITE_CYCLES(300)) sfs_status_top_i (.clk(clk), .rst_b(rst_b),
		.link_sck(link_sck), .ce_b(ce_b), .si(si), .wp_b(wp_b), .array_done(array_done),
		.so(so), .so_oe(so_oe), .flash_status(flash_status),
		.quad_lines_enable(quad_lines_enable), .array_op(array_op),
		.suspend_req(suspend_req), .soft_reset(soft_reset));
	sfs_host sfs_host_i (.link_sck(link_sck), .ce_b(ce_b), .si(si), .so(so_line));
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic send(input logic [31:0] d, input int n);
		sfs_host_i.xfer(d, n, rd);
	endtask
	task automatic done_pulse;
		tick(1);
		array_done = 1'b1;
		tick(1);
		array_done = 1'b0;
		tick(3);
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		wp_b = 1'b1;
		array_done = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		rows = '{'{32'h06000000, 8'h08, 16'h0006, 8'h02},
			'{32'h04000000, 8'h08, 16'h0006, 8'h00},
			'{32'h01FC0000, 8'h10, 16'h0006, 8'h00},
			'{32'h06000000, 8'h08, 16'h0006, 8'h02},
			'{32'h013C0000, 8'h10, 16'h0008, 8'h03},
			'{32'h06000000, 8'h08, 16'h0190, 8'h3C},
			'{32'h06000000, 8'h08, 16'h0006, 8'h3E},
			'{32'hC7000000, 8'h08, 16'h0006, 8'h3E},
			'{32'h02001234, 8'h20, 16'h0004, 8'h3F}};
		tick(20);
		rst_b = 1'b1;
		tick(3);
		chk("reset", 24'h000000, 24'(flash_status));
		foreach (rows[i]) begin
			send(rows[i].d, int'(rows[i].n));
			tick(int'(rows[i].w));
			chk("status", 24'(rows[i].e), 24'(flash_status));
			send({CMD_STATUS_READ, 24'h000000}, 24);
			chk("read", {8'h00, rows[i].e, rows[i].e}, 24'(rd));
		end
		done_pulse();
		chk("done", 24'h00003C, 24'(flash_status));
		send({CMD_SET_WE, 24'h000000}, 8);
		send({CMD_SECTOR_ERASE, 24'h012345}, 32);
		chk("erase_addr", 24'h012000, array_op.addr);
		chk("erase_kind", 24'(OP_SECTOR_ERASE), 24'(array_op.kind));
		send({CMD_SUSPEND, 24'h000000}, 8);
		done_pulse();
		chk("suspend", 24'h00003E, 24'(flash_status));
		send({CMD_RESUME, 24'h000000}, 8);
		chk("resume", 24'h00003F, 24'(flash_status));
		send({CMD_SOFT_RESET, 24'h000000}, 8);
		chk("soft_reset", 24'h00003C, 24'(flash_status));
		send({CMD_SET_WE, 24'h000000}, 8);
		send({CMD_STATUS_WRITE, 8'h80, 16'h0000}, 16);
		tick(320);
		chk("lock_set", 24'h000080, 24'(flash_status));
		wp_b = 1'b0;
		send({CMD_SET_WE, 24'h000000}, 8);
		send({CMD_STATUS_WRITE, 8'h3C, 16'h0000}, 16);
		tick(320);
		chk("locked", 24'h000082, 24'(flash_status));
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(3);
		chk("rereset", 24'h000000, 24'(flash_status));
		// With four-line mode on, the protect pin is data and cannot lock.
		send({CMD_SET_WE, 24'h000000}, 8);
		send({CMD_STATUS_WRITE, 8'hC0, 16'h0000}, 16);
		tick(320);
		chk("quad_set", 24'h0000C0, 24'(flash_status));
		chk("quad_port", 24'h000001, 24'(quad_lines_enable));
		send({CMD_SET_WE, 24'h000000}, 8);
		send({CMD_STATUS_WRITE, 8'h40, 16'h0000}, 16);
		tick(320);
		chk("quad_unlock", 24'h000040, 24'(flash_status));
		wrap_up();
	end
endmodule // test_sfs_status_top
bind sfs_status_top sfs_status_chk sfs_status_chk_i (.clk(clk), .rst_b(rst_b),
	.link_sck(link_sck), .ce_b(ce_b), .si(si), .wp_b(wp_b), .array_done(array_done),
	.so(so), .so_oe(so_oe), .flash_status(flash_status),
	.quad_lines_enable(quad_lines_enable), .array_op(array_op),
	.suspend_req(suspend_req), .soft_reset(soft_reset));
